// file: pin_dir_pkg.sv
// Functional notes
// - Port B clock pin as GPIO: direction bit one drives output, zero input.
// - Port B clock direction is bit 4 of serial register, resets zero.
// - Bit 3 sets port A slave-select GPIO direction; resets zero.
// - Bit 2 sets port A master-out GPIO direction; read/write, resets zero.
// - Bit 1 sets port A master-in GPIO direction; read/write, resets zero.
// - Bit 0 sets port A clock GPIO direction; read/write, resets zero.
// - Pin not selected as GPIO ignores its direction bit entirely.
// - UART direction register at 0x0088; bits 31:16 read-only zero.
// - UART bit 15 sets UART C receive pin GPIO direction; resets zero.
// - UART bit 14 sets UART C clear-to-send GPIO direction; resets zero.
package pin_dir_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [31:0] SPI_DIR_OFFSET = 32'h0000_0084;
  localparam logic [31:0] UART_DIR_OFFSET = 32'h0000_0088;
  localparam logic [31:0] SPI_DIR_RESET = 32'h0000_0000;
  localparam logic [31:0] UART_DIR_RESET = 32'h0000_0000;
  localparam logic [31:0] SPI_DIR_WMASK = 32'h0000_001f;
  localparam logic [31:0] UART_DIR_WMASK = 32'h0000_c000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PORT_A_CLK_BIT = 0;
  localparam int PORT_A_MISO_BIT = 1;
  localparam int PORT_A_MOSI_BIT = 2;
  localparam int PORT_A_SS_BIT = 3;
  localparam int PORT_B_CLK_BIT = 4;
  localparam int UART_C_CTS_BIT = 14;
  localparam int UART_C_RXD_BIT = 15;

  // ****************************************
  // Bus responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic aw_full;
    logic [31:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] spi_dir;
    logic [31:0] uart_dir;
    logic [6:0] drive_n;
  } state_s;

endpackage

// file: pin_dir_ctrl.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module pin_dir_ctrl
  import pin_dir_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port_a_serial_clock_pin_gpio_sel,
  input wire logic port_a_master_in_pin_gpio_sel,
  input wire logic port_a_master_out_pin_gpio_sel,
  input wire logic port_a_slave_select_pin_gpio_sel,
  input wire logic port_b_serial_clock_pin_gpio_sel,
  input wire logic uart_c_clear_to_send_pin_gpio_sel,
  input wire logic uart_c_receive_pin_gpio_sel,
  output logic port_a_serial_clock_pin_oe_n,
  output logic port_a_master_in_pin_oe_n,
  output logic port_a_master_out_pin_oe_n,
  output logic port_a_slave_select_pin_oe_n,
  output logic port_b_serial_clock_pin_oe_n,
  output logic uart_c_clear_to_send_pin_oe_n,
  output logic uart_c_receive_pin_oe_n
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_spi(input logic [31:0] addr);
    is_spi = (addr[31:2] == SPI_DIR_OFFSET[31:2]);
  endfunction

  function automatic logic is_uart(input logic [31:0] addr);
    is_uart = (addr[31:2] == UART_DIR_OFFSET[31:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb,
                                        input logic [31:0] wmask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge = (old & ~m) | (data & m);
  endfunction

  // Driver enable, active low
  function automatic logic drive_off(input logic sel, input logic dir);
    drive_off = ~(sel & dir);
  endfunction

  state_s s_reg;
  state_s s_next;
  logic [6:0] sel;

  assign sel = {uart_c_receive_pin_gpio_sel,
                uart_c_clear_to_send_pin_gpio_sel,
                port_b_serial_clock_pin_gpio_sel,
                port_a_slave_select_pin_gpio_sel,
                port_a_master_out_pin_gpio_sel,
                port_a_master_in_pin_gpio_sel,
                port_a_serial_clock_pin_gpio_sel};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // Write address and data, either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if (is_spi(s_reg.aw_addr)) begin
        s_next.spi_dir = merge(s_reg.spi_dir, s_reg.w_data, s_reg.w_strb,
                               SPI_DIR_WMASK);
      end else if (is_uart(s_reg.aw_addr)) begin
        s_next.uart_dir = merge(s_reg.uart_dir, s_reg.w_data, s_reg.w_strb,
                                UART_DIR_WMASK);
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end
    s_next.awready = !s_next.aw_full && !s_next.bvalid;
    s_next.wready = !s_next.w_full && !s_next.bvalid;

    // Read channel
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      if (is_spi(s_axi_araddr)) begin
        s_next.rdata = s_reg.spi_dir & SPI_DIR_WMASK;
        s_next.rresp = RESP_OKAY;
      end else if (is_uart(s_axi_araddr)) begin
        s_next.rdata = s_reg.uart_dir & UART_DIR_WMASK;
        s_next.rresp = RESP_OKAY;
      end else begin
        s_next.rdata = '0;
        s_next.rresp = RESP_SLVERR;
      end
    end
    s_next.arready = !s_next.rvalid;

    // Pad drivers: off unless pin selected as GPIO and set as output
    s_next.drive_n[0] = drive_off(sel[0],
                                  s_next.spi_dir[PORT_A_CLK_BIT]);
    s_next.drive_n[1] = drive_off(sel[1],
                                  s_next.spi_dir[PORT_A_MISO_BIT]);
    s_next.drive_n[2] = drive_off(sel[2],
                                  s_next.spi_dir[PORT_A_MOSI_BIT]);
    s_next.drive_n[3] = drive_off(sel[3],
                                  s_next.spi_dir[PORT_A_SS_BIT]);
    s_next.drive_n[4] = drive_off(sel[4],
                                  s_next.spi_dir[PORT_B_CLK_BIT]);
    s_next.drive_n[5] = drive_off(sel[5],
                                  s_next.uart_dir[UART_C_CTS_BIT]);
    s_next.drive_n[6] = drive_off(sel[6],
                                  s_next.uart_dir[UART_C_RXD_BIT]);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg.aw_full <= 1'b0;
      s_reg.aw_addr <= '0;
      s_reg.w_full <= 1'b0;
      s_reg.w_data <= '0;
      s_reg.w_strb <= '0;
      s_reg.awready <= 1'b0;
      s_reg.wready <= 1'b0;
      s_reg.bvalid <= 1'b0;
      s_reg.bresp <= RESP_OKAY;
      s_reg.arready <= 1'b0;
      s_reg.rvalid <= 1'b0;
      s_reg.rdata <= '0;
      s_reg.rresp <= RESP_OKAY;
      s_reg.spi_dir <= SPI_DIR_RESET;
      s_reg.uart_dir <= UART_DIR_RESET;
      s_reg.drive_n <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign port_a_serial_clock_pin_oe_n = s_reg.drive_n[0];
  assign port_a_master_in_pin_oe_n = s_reg.drive_n[1];
  assign port_a_master_out_pin_oe_n = s_reg.drive_n[2];
  assign port_a_slave_select_pin_oe_n = s_reg.drive_n[3];
  assign port_b_serial_clock_pin_oe_n = s_reg.drive_n[4];
  assign uart_c_clear_to_send_pin_oe_n = s_reg.drive_n[5];
  assign uart_c_receive_pin_oe_n = s_reg.drive_n[6];

endmodule

// file: pin_dir_ctrl_assertions.sv
`timescale 1ns/1ps
module pin_dir_ctrl_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic port_a_serial_clock_pin_gpio_sel,
  input wire logic port_a_serial_clock_pin_oe_n,
  input wire logic port_b_serial_clock_pin_gpio_sel,
  input wire logic port_b_serial_clock_pin_oe_n,
  input wire logic uart_c_receive_pin_gpio_sel,
  input wire logic uart_c_receive_pin_oe_n
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("r lost");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r late");
  a_reserved_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("resv");
  a_unused_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[13:5] == 9'h000) else $error("unused");
  a_port_b_ignored: assert property (
    !port_b_serial_clock_pin_gpio_sel |=> port_b_serial_clock_pin_oe_n)
    else $error("b clk driven");
  a_uart_rx_ignored: assert property (
    !uart_c_receive_pin_gpio_sel |=> uart_c_receive_pin_oe_n)
    else $error("rx driven");
  a_drive_needs_sel: assert property (
    $fell(port_a_serial_clock_pin_oe_n) |-> $past(port_a_serial_clock_pin_gpio_sel))
    else $error("a clk driven");
  a_write_blocks: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready");
endmodule
bind pin_dir_ctrl pin_dir_ctrl_assertions pin_dir_ctrl_assertions_inst (.*);

// file: pin_dir_ctrl_tb_top.sv
`timescale 1ns/1ps
module pin_dir_ctrl_tb_top import pin_dir_pkg::*; ();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic port_a_serial_clock_pin_gpio_sel, port_a_master_in_pin_gpio_sel;
  logic port_a_master_out_pin_gpio_sel, port_a_slave_select_pin_gpio_sel;
  logic port_b_serial_clock_pin_gpio_sel, uart_c_clear_to_send_pin_gpio_sel;
  logic uart_c_receive_pin_gpio_sel, port_a_serial_clock_pin_oe_n;
  logic port_a_master_in_pin_oe_n, port_a_master_out_pin_oe_n;
  logic port_a_slave_select_pin_oe_n, port_b_serial_clock_pin_oe_n;
  logic uart_c_clear_to_send_pin_oe_n, uart_c_receive_pin_oe_n;
  logic [6:0] sel = 7'h00;
  logic [31:0] oe_n, rd;
  int failures = 0, samples_checked = 0, cycles = 0;
  assign {uart_c_receive_pin_gpio_sel, uart_c_clear_to_send_pin_gpio_sel,
    port_b_serial_clock_pin_gpio_sel, port_a_slave_select_pin_gpio_sel,
    port_a_master_out_pin_gpio_sel, port_a_master_in_pin_gpio_sel,
    port_a_serial_clock_pin_gpio_sel} = sel;
  assign oe_n = {25'h0, uart_c_receive_pin_oe_n, uart_c_clear_to_send_pin_oe_n,
    port_b_serial_clock_pin_oe_n, port_a_slave_select_pin_oe_n,
    port_a_master_out_pin_oe_n, port_a_master_in_pin_oe_n,
    port_a_serial_clock_pin_oe_n};
  pin_dir_ctrl pin_dir_ctrl_inst (.*);
  always #25 aclk = ~aclk;
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdw(logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    sel <= 7'h7f;
    rdw(SPI_DIR_OFFSET);
    chk("spi reset", rd, 32'h0);
    rdw(UART_DIR_OFFSET);
    chk("uart reset", rd, 32'h0);
    chk("oe reset", oe_n, 32'h7f);
    $display("test reset done");
    wr(SPI_DIR_OFFSET, 32'hffff_ffff);
    chk("bresp ok", {30'h0, rsp}, {30'h0, RESP_OKAY});
    wr(UART_DIR_OFFSET, 32'hffff_ffff);
    rdw(SPI_DIR_OFFSET);
    chk("spi all", rd, 32'h1f);
    rdw(UART_DIR_OFFSET);
    chk("uart all", rd, 32'hc000);
    chk("oe all", oe_n, 32'h0);
    @(posedge aclk);
    sel <= 7'h2a;
    repeat (2) @(posedge aclk);
    chk("oe partial", oe_n, 32'h55);
    sel <= 7'h00;
    repeat (2) @(posedge aclk);
    chk("oe none", oe_n, 32'h7f);
    sel <= 7'h7f;
    $display("test select done");
    for (int j = 0; j < 7; j++) begin
      wr(SPI_DIR_OFFSET, (j < 5) ? 32'h1 << j : 32'h0);
      wr(UART_DIR_OFFSET, (j < 5) ? 32'h0 : 32'h1 << (j + 9));
      chk("oe walk", oe_n, ~(32'h1 << j) & 32'h7f);
    end
    $display("test walk done");
    wr(32'h0000_0100, 32'hffff_ffff);
    chk("bresp bad", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    rdw(32'h0000_0100);
    chk("rresp bad", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("rdata bad", rd, 32'h0);
    rdw(UART_DIR_OFFSET);
    chk("uart kept", rd, 32'h8000);
    $display("test unmapped done");
    s_axi_wstrb <= 4'h1;
    wr(UART_DIR_OFFSET, 32'h0);
    rdw(UART_DIR_OFFSET);
    chk("lane off", rd, 32'h8000);
    s_axi_wstrb <= 4'h2;
    wr(UART_DIR_OFFSET, 32'h0);
    rdw(UART_DIR_OFFSET);
    chk("lane on", rd, 32'h0);
    s_axi_wstrb <= 4'hf;
    $display("test strobe done");
    wr(SPI_DIR_OFFSET, 32'hffff_ffff);
    wr(UART_DIR_OFFSET, 32'hffff_ffff);
    chk("oe set", oe_n, 32'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdw(SPI_DIR_OFFSET);
    chk("spi rerst", rd, SPI_DIR_RESET);
    rdw(UART_DIR_OFFSET);
    chk("uart rerst", rd, UART_DIR_RESET);
    chk("oe rerst", oe_n, 32'h7f);
    $display("test reset again done");
    wrap_up();
  end
endmodule
